// >>> hw/mqrs_pkg.sv
package mqrs_pkg;

	// Queue setup storage
	localparam int QUEUES = 32;
	localparam int QIDX_W = 5;
	localparam int QCNT_W = 6;
	localparam int HDR_BITS = 19;
	localparam int QBITS = 72;
	localparam int BITCNT_W = 12;
	localparam int QBIT_W = 7;

	// Header field holding the queue count minus one
	localparam int HDR_QCNT_LSB = 0;

	// Per-queue word layout
	localparam int FIELD_W = 16;
	localparam int AE_OFS_LSB = 0;
	localparam int AF_OFS_LSB = 16;
	localparam int DEPTH_LSB = 32;

	// Default programming values
	localparam logic [15:0] OFS_LOW = 16'h0008;
	localparam logic [15:0] OFS_HIGH = 16'h0080;
	localparam logic [15:0] DEF_DEPTH = 16'h0800;

	// Partial reset timing in port clock edges
	localparam logic [1:0] PRS_SEL_EDGES = 2'h2;
	localparam logic [1:0] PRS_RECOV_EDGES = 2'h3;

	// Register map
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_STRAP = 8'h04;
	localparam logic [7:0] REG_QSEL = 8'h08;
	localparam logic [7:0] REG_QWORD0 = 8'h0c;
	localparam logic [7:0] REG_QWORD1 = 8'h10;
	localparam logic [7:0] REG_QWORD2 = 8'h14;
	localparam logic [4:0] QSEL_RST = 5'h00;

	// Status register bits
	localparam int ST_QCNT_LSB = 0;
	localparam int ST_DONE_BIT = 8;
	localparam int ST_OK_BIT = 9;
	localparam int ST_SRC_BIT = 10;

	typedef enum logic [2:0] {
		ST_WAIT,
		ST_MRS,
		ST_SERIAL,
		ST_DEFAULT,
		ST_DONE
	} mqrs_state_t;

	function automatic logic [11:0] total_bits(input logic [5:0] q);
		return 12'(HDR_BITS + QBITS * int'(q));
	endfunction

endpackage

// >>> hw/mqrs_pin_sync.sv
`timescale 1ns/100ps
module mqrs_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] lvl_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic live_q;

	// First stage feeds only the second; edges come from later stages.
	// Stages keep shifting through reset: clearing them would fake a low
	// level and a false edge on the idle-high pins at release.
	always_ff @(posedge clk_i) begin
		s1_q <= d_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end

	assign lvl_o = s2_q;
	assign rise_o = s2_q & ~s3_q & {W{live_q}};
	assign fall_o = ~s2_q & s3_q & {W{live_q}};
endmodule

// >>> hw/mqrs_config_loader.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
module mqrs_config_loader (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic full_reset_n_i,
	input wire logic flag_bus_style_sel_i,
	input wire logic input_width_sel_i,
	input wire logic output_width_sel_i,
	input wire logic primary_device_sel_i,
	input wire logic device_id_bit0_i,
	input wire logic device_id_bit1_i,
	input wire logic device_id_bit2_i,
	input wire logic programming_source_sel_i,
	input wire logic default_offset_sel_i,
	input wire logic sclk_i,
	input wire logic si_i,
	input wire logic load_enable_in_n_i,
	output logic load_done_out_n_o,
	output logic so_o,
	input wire logic wclk_i,
	input wire logic rclk_i,
	input wire logic [4:0] wr_queue_sel_i,
	input wire logic [4:0] rd_queue_sel_i,
	input wire logic queue_pointer_reset_n_i,
	output logic ptr_clear_o,
	output logic [4:0] ptr_clear_queue_o,
	output logic queue_access_ok_o,
	output logic config_done_o,
	output logic flag_bus_style_o,
	output logic input_width_o,
	output logic output_width_o,
	output logic primary_device_o,
	output logic [2:0] device_id_o,
	output logic [5:0] queue_count_o,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	localparam int NPIN = 26;

	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic mrs_l;
	logic sclk_rise;
	logic si_l;
	logic load_enable_in_n_l;
	logic wclk_rise;
	logic rclk_rise;
	logic prs_l;
	logic prs_rise;
	logic prs_fall;
	logic [4:0] wsel_l;
	logic [4:0] rsel_l;

	mqrs_pkg::mqrs_state_t state_q;
	logic fm_q;
	logic iw_q;
	logic ow_q;
	logic primary_device_sel_q;
	logic [2:0] id_q;
	logic prog_src_q;
	logic df_q;

	logic [11:0] bit_cnt_q;
	logic [71:0] shift_q;
	logic [18:0] hdr_q;
	logic [5:0] q_count_q;
	logic [6:0] qbit_q;
	logic [4:0] widx_q;
	logic [71:0] mem [mqrs_pkg::QUEUES];
	logic ser_take;
	logic hdr_end;
	logic word_end;
	logic ser_last;
	logic def_take;
	logic def_last;
	logic mem_we;
	logic [71:0] mem_wdata;
	logic done;

	logic [4:0] wsel_q;
	logic [4:0] rsel_q;
	logic [1:0] wstab_q;
	logic [1:0] rstab_q;
	logic arm_q;
	logic wlow_q;
	logic rlow_q;
	logic [1:0] wpost_q;
	logic [1:0] rpost_q;
	logic ptr_clear_q;
	logic [4:0] ptr_queue_q;

	logic [4:0] qsel_q;
	logic [31:0] rdata_q;
	logic [71:0] qword;

	mqrs_pin_sync #(
		.W(NPIN)
	) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i({full_reset_n_i, sclk_i, si_i, load_enable_in_n_i, wclk_i,
			rclk_i, queue_pointer_reset_n_i, flag_bus_style_sel_i,
			input_width_sel_i, output_width_sel_i, primary_device_sel_i,
			device_id_bit2_i, device_id_bit1_i, device_id_bit0_i,
			programming_source_sel_i, default_offset_sel_i,
			wr_queue_sel_i, rd_queue_sel_i}),
		.lvl_o(pin_lvl),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	assign mrs_l = pin_lvl[25];
	assign sclk_rise = pin_rise[24];
	assign si_l = pin_lvl[23];
	assign load_enable_in_n_l = pin_lvl[22];
	assign wclk_rise = pin_rise[21];
	assign rclk_rise = pin_rise[20];
	assign prs_l = pin_lvl[19];
	assign prs_rise = pin_rise[19];
	assign prs_fall = pin_fall[19];
	assign wsel_l = pin_lvl[9:5];
	assign rsel_l = pin_lvl[4:0];

	// Power-up waits for a master reset before anything can be loaded
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_q <= mqrs_pkg::ST_WAIT;
		end else if (!mrs_l) begin
			state_q <= mqrs_pkg::ST_MRS;
		end else begin
			unique case (state_q)
				mqrs_pkg::ST_WAIT: begin
					state_q <= mqrs_pkg::ST_WAIT;
				end
				mqrs_pkg::ST_MRS: begin
					state_q <= prog_src_q ? mqrs_pkg::ST_DEFAULT :
						mqrs_pkg::ST_SERIAL;
				end
				mqrs_pkg::ST_SERIAL: begin
					if (ser_last) begin
						state_q <= mqrs_pkg::ST_DONE;
					end
				end
				mqrs_pkg::ST_DEFAULT: begin
					if (def_last) begin
						state_q <= mqrs_pkg::ST_DONE;
					end
				end
				mqrs_pkg::ST_DONE: begin
					state_q <= mqrs_pkg::ST_DONE;
				end
				default: begin
					state_q <= mqrs_pkg::ST_WAIT;
				end
			endcase
		end
	end

	assign done = (state_q == mqrs_pkg::ST_DONE);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fm_q <= 1'b0;
			iw_q <= 1'b0;
			ow_q <= 1'b0;
			primary_device_sel_q <= 1'b0;
			id_q <= 3'h0;
			prog_src_q <= 1'b0;
			df_q <= 1'b0;
		end else if (!mrs_l) begin
			fm_q <= pin_lvl[18];
			iw_q <= pin_lvl[17];
			ow_q <= pin_lvl[16];
			primary_device_sel_q <= pin_lvl[15];
			id_q <= pin_lvl[14:12];
			prog_src_q <= pin_lvl[11];
			df_q <= pin_lvl[10];
		end
	end

	assign ser_take = (state_q == mqrs_pkg::ST_SERIAL) && sclk_rise &&
		!load_enable_in_n_l;
	assign hdr_end = ser_take &&
		(bit_cnt_q == 12'(mqrs_pkg::HDR_BITS - 1));
	assign word_end = ser_take &&
		(bit_cnt_q >= 12'(mqrs_pkg::HDR_BITS)) &&
		(qbit_q == 7'(mqrs_pkg::QBITS - 1));
	assign ser_last = word_end &&
		({1'b0, widx_q} + 6'h01 == q_count_q);
	assign def_take = (state_q == mqrs_pkg::ST_DEFAULT) && wclk_rise;
	assign def_last = def_take &&
		(widx_q == 5'(mqrs_pkg::QUEUES - 1));

	always_ff @(posedge clk_i) begin
		if (!reset_n_i || state_q == mqrs_pkg::ST_MRS) begin
			bit_cnt_q <= 12'h000;
			qbit_q <= 7'h00;
		end else if (ser_take) begin
			bit_cnt_q <= bit_cnt_q + 12'h001;
			if (bit_cnt_q >= 12'(mqrs_pkg::HDR_BITS)) begin
				qbit_q <= word_end ? 7'h00 : qbit_q + 7'h01;
			end
		end
	end

	// MSB first: each new bit enters at the bottom
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			shift_q <= '0;
			hdr_q <= '0;
		end else if (ser_take) begin
			shift_q <= {shift_q[70:0], si_l};
			if (hdr_end) begin
				hdr_q <= {shift_q[17:0], si_l};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			q_count_q <= 6'h00;
		end else if (state_q == mqrs_pkg::ST_MRS) begin
			q_count_q <= prog_src_q ? 6'(mqrs_pkg::QUEUES) : 6'h00;
		end else if (hdr_end) begin
			q_count_q <= {1'b0, shift_q[mqrs_pkg::HDR_QCNT_LSB +: 4],
				si_l} + 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i || state_q == mqrs_pkg::ST_MRS) begin
			widx_q <= 5'h00;
		end else if (mem_we && !(ser_last || def_last)) begin
			widx_q <= widx_q + 5'h01;
		end
	end

	always_comb begin
		mem_we = word_end || def_take;
		mem_wdata = '0;
		if (def_take) begin
			mem_wdata[mqrs_pkg::AE_OFS_LSB +: mqrs_pkg::FIELD_W] =
				df_q ? mqrs_pkg::OFS_HIGH : mqrs_pkg::OFS_LOW;
			mem_wdata[mqrs_pkg::AF_OFS_LSB +: mqrs_pkg::FIELD_W] =
				df_q ? mqrs_pkg::OFS_HIGH : mqrs_pkg::OFS_LOW;
			mem_wdata[mqrs_pkg::DEPTH_LSB +: mqrs_pkg::FIELD_W] =
				mqrs_pkg::DEF_DEPTH;
		end else begin
			mem_wdata = {shift_q[70:0], si_l};
		end
	end

	// Setup words are data, so no reset; a default load rewrites all 32, a serial load only the first queue-count words
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[widx_q] <= mem_wdata;
		end
	end

	// Pass-through is combinational so chained devices see no extra delay
	assign load_done_out_n_o = done ? load_enable_in_n_i : 1'b1;
	assign so_o = done ? si_i : 1'b0;
	assign config_done_o = done;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wsel_q <= 5'h00;
			wstab_q <= 2'h0;
		end else if (wclk_rise) begin
			wsel_q <= wsel_l;
			if (wsel_l != wsel_q) begin
				wstab_q <= 2'h1;
			end else if (wstab_q != mqrs_pkg::PRS_SEL_EDGES) begin
				wstab_q <= wstab_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rsel_q <= 5'h00;
			rstab_q <= 2'h0;
		end else if (rclk_rise) begin
			rsel_q <= rsel_l;
			if (rsel_l != rsel_q) begin
				rstab_q <= 2'h1;
			end else if (rstab_q != mqrs_pkg::PRS_SEL_EDGES) begin
				rstab_q <= rstab_q + 2'h1;
			end
		end
	end

	// A partial reset without a settled common selection is ignored
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			arm_q <= 1'b0;
			wlow_q <= 1'b0;
			rlow_q <= 1'b0;
		end else if (prs_fall) begin
			arm_q <= done && (wsel_q == rsel_q) &&
				(wstab_q == mqrs_pkg::PRS_SEL_EDGES) &&
				(rstab_q == mqrs_pkg::PRS_SEL_EDGES);
			wlow_q <= 1'b0;
			rlow_q <= 1'b0;
		end else if (!prs_l) begin
			wlow_q <= wlow_q | wclk_rise;
			rlow_q <= rlow_q | rclk_rise;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ptr_clear_q <= 1'b0;
			ptr_queue_q <= 5'h00;
		end else begin
			ptr_clear_q <= prs_rise && arm_q && wlow_q && rlow_q;
			if (prs_rise) begin
				ptr_queue_q <= wsel_q;
			end
		end
	end

	assign ptr_clear_o = ptr_clear_q;
	assign ptr_clear_queue_o = ptr_queue_q;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wpost_q <= mqrs_pkg::PRS_RECOV_EDGES;
			rpost_q <= mqrs_pkg::PRS_RECOV_EDGES;
		end else if (prs_rise && arm_q && wlow_q && rlow_q) begin
			wpost_q <= 2'h0;
			rpost_q <= 2'h0;
		end else begin
			if (wclk_rise && wpost_q != mqrs_pkg::PRS_RECOV_EDGES) begin
				wpost_q <= wpost_q + 2'h1;
			end
			if (rclk_rise && rpost_q != mqrs_pkg::PRS_RECOV_EDGES) begin
				rpost_q <= rpost_q + 2'h1;
			end
		end
	end

	assign queue_access_ok_o = done && prs_l && !ptr_clear_q &&
		(wpost_q == mqrs_pkg::PRS_RECOV_EDGES) &&
		(rpost_q == mqrs_pkg::PRS_RECOV_EDGES);

	assign flag_bus_style_o = fm_q;
	assign input_width_o = iw_q;
	assign output_width_o = ow_q;
	assign primary_device_o = primary_device_sel_q;
	assign device_id_o = id_q;
	assign queue_count_o = q_count_q;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			qsel_q <= mqrs_pkg::QSEL_RST;
		end else if (reg_wr_i && reg_addr_i == mqrs_pkg::REG_QSEL) begin
			qsel_q <= reg_wdata_i[4:0];
		end
	end

	assign qword = mem[qsel_q];

	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !reg_rd_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			unique case (reg_addr_i)
				mqrs_pkg::REG_STATUS: begin
					rdata_q[mqrs_pkg::ST_QCNT_LSB +: 6] <= q_count_q;
					rdata_q[mqrs_pkg::ST_DONE_BIT] <= done;
					rdata_q[mqrs_pkg::ST_OK_BIT] <= queue_access_ok_o;
					rdata_q[mqrs_pkg::ST_SRC_BIT] <= prog_src_q;
				end
				mqrs_pkg::REG_STRAP: begin
					rdata_q[8:0] <= {prog_src_q, df_q, id_q, primary_device_sel_q, ow_q,
						iw_q, fm_q};
				end
				mqrs_pkg::REG_QSEL: rdata_q[4:0] <= qsel_q;
				mqrs_pkg::REG_QWORD0: rdata_q <= qword[31:0];
				mqrs_pkg::REG_QWORD1: rdata_q <= qword[63:32];
				mqrs_pkg::REG_QWORD2: rdata_q[7:0] <= qword[71:64];
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_mrs_init;
		!mrs_l |=> state_q == mqrs_pkg::ST_MRS && load_done_out_n_o &&
			!queue_access_ok_o;
	endproperty
	a_mrs_init: assert property (p_mrs_init)
		else $error("master reset did not reinitialise");

	property p_strap;
		!mrs_l |=> prog_src_q == $past(pin_lvl[11]) &&
			df_q == $past(pin_lvl[10]) && id_q == $past(pin_lvl[14:12]);
	endproperty
	a_strap: assert property (p_strap)
		else $error("strap not captured in master reset");

	property p_gate;
		queue_access_ok_o |-> done && prs_l;
	endproperty
	a_gate: assert property (p_gate)
		else $error("access allowed before programming done");

	property p_clear_queue;
		ptr_clear_o |-> ptr_clear_queue_o == $past(wsel_q) &&
			$past(arm_q) && !queue_access_ok_o;
	endproperty
	a_clear_queue: assert property (p_clear_queue)
		else $error("pointer clear for wrong or unarmed queue");

	property p_recover;
		ptr_clear_o |-> !queue_access_ok_o [*5];
	endproperty
	a_recover: assert property (p_recover)
		else $error("access resumed too soon after partial reset");

	property p_serial_wait;
		state_q == mqrs_pkg::ST_SERIAL |-> load_done_out_n_o && !so_o &&
			!config_done_o;
	endproperty
	a_serial_wait: assert property (p_serial_wait)
		else $error("done shown before serial load finished");

	property p_count;
		state_q == mqrs_pkg::ST_SERIAL ##1 state_q == mqrs_pkg::ST_DONE
			|-> bit_cnt_q == mqrs_pkg::total_bits(q_count_q);
	endproperty
	a_count: assert property (p_count)
		else $error("serial bit count mismatch at done");

	property p_take;
		ser_take |=> bit_cnt_q == $past(bit_cnt_q) + 12'h001 &&
			shift_q[0] == $past(si_l);
	endproperty
	a_take: assert property (p_take)
		else $error("serial bit not captured");

	property p_follow;
		config_done_o |-> load_done_out_n_o == load_enable_in_n_i &&
			so_o == si_i;
	endproperty
	a_follow: assert property (p_follow)
		else $error("pass-through not following inputs");

	property p_def_ofs;
		state_q == mqrs_pkg::ST_DEFAULT ##1 state_q == mqrs_pkg::ST_DONE
			|-> mem[0][mqrs_pkg::AF_OFS_LSB +: mqrs_pkg::FIELD_W] ==
			(df_q ? mqrs_pkg::OFS_HIGH : mqrs_pkg::OFS_LOW);
	endproperty
	a_def_ofs: assert property (p_def_ofs)
		else $error("default offset wrong");

	c_serial_done: cover property (
		state_q == mqrs_pkg::ST_SERIAL ##1 done);
	c_default_done: cover property (
		state_q == mqrs_pkg::ST_DEFAULT ##1 done);
	c_ptr_clear: cover property (ptr_clear_o ##[1:100] queue_access_ok_o);
endmodule

// >>> sim/mqrs_host_model.sv
`timescale 1ns/100ps
module mqrs_host_model (
	input wire logic clk_i,
	input wire logic load_done_out_n_i,
	output logic full_reset_n_o,
	output logic sclk_o,
	output logic si_o,
	output logic load_enable_in_n_o
);
	initial begin
		full_reset_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b0;
		load_enable_in_n_o = 1'b1;
	end
	// Low held past the two-flop synchroniser on the pin
	task automatic master_reset();
		@(posedge clk_i);
		full_reset_n_o <= 1'b0;
		repeat (5) @(posedge clk_i);
		full_reset_n_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic pins(input logic en_n, input logic d);
		load_enable_in_n_o = en_n;
		si_o = d;
	endtask
	// Bits top-1 down to stop, MSB first; clock stands low between frames
	task automatic load(input logic [234:0] s, input int top, input int stop);
		load_enable_in_n_o <= 1'b0;
		for (int i = top - 1; i >= stop; i--) begin
			if (load_done_out_n_i === 1'b0)
				break;
			si_o <= s[i];
			#62.5 sclk_o <= 1'b1;
			#62.5 sclk_o <= 1'b0;
		end
	endtask
endmodule

// >>> sim/multiqueue_reset_and_serial_setup_tb_top.sv
`timescale 1ns/100ps
module multiqueue_reset_and_serial_setup_tb_top;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic frst_n, sclk, si, sen_n, done_n, so;
	logic [8:0] st = 9'h000;
	logic wclk = 1'b0;
	logic rclk = 1'b0;
	logic [4:0] wsel = 5'h00;
	logic [4:0] rsel = 5'h00;
	logic prs_n = 1'b1;
	logic clr, ok, cdone, fm, iw, ow, prim, hit;
	logic [2:0] did;
	logic [5:0] qc;
	logic [4:0] clrq, pq;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, r;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [71:0] w [0:2];
	logic [234:0] s;
	logic [15:0] ofs;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	int q, n;
	always #5 clk_i = ~clk_i;
	// Port clocks of 40 ns and 60 ns, sampled by the block
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		wclk <= (cyc % 4) >= 2;
		rclk <= (cyc % 6) >= 3;
	end
	mqrs_host_model mqrs_host_model_inst (.clk_i(clk_i),
		.load_done_out_n_i(done_n), .full_reset_n_o(frst_n),
		.sclk_o(sclk), .si_o(si), .load_enable_in_n_o(sen_n));
	mqrs_config_loader mqrs_config_loader_inst (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .full_reset_n_i(frst_n),
		.flag_bus_style_sel_i(st[0]), .input_width_sel_i(st[1]),
		.output_width_sel_i(st[2]), .primary_device_sel_i(st[3]),
		.device_id_bit0_i(st[4]), .device_id_bit1_i(st[5]),
		.device_id_bit2_i(st[6]), .default_offset_sel_i(st[7]),
		.programming_source_sel_i(st[8]), .sclk_i(sclk), .si_i(si),
		.load_enable_in_n_i(sen_n), .load_done_out_n_o(done_n),
		.so_o(so), .wclk_i(wclk), .rclk_i(rclk), .wr_queue_sel_i(wsel),
		.rd_queue_sel_i(rsel), .queue_pointer_reset_n_i(prs_n),
		.ptr_clear_o(clr), .ptr_clear_queue_o(clrq),
		.queue_access_ok_o(ok), .config_done_o(cdone),
		.flag_bus_style_o(fm), .input_width_o(iw), .output_width_o(ow),
		.primary_device_o(prim), .device_id_o(did), .queue_count_o(qc),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata));
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic part_reset(input logic [4:0] wq, input logic [4:0] rq);
		@(posedge clk_i);
		wsel <= wq;
		rsel <= rq;
		repeat (30) @(posedge clk_i);
		prs_n <= 1'b0;
		repeat (20) @(posedge clk_i);
		#1 chk({31'h0, ok}, 32'h0);
		prs_n <= 1'b1;
		hit = 1'b0;
		for (int k = 0; k < 15 && hit !== 1'b1; k++) begin
			@(posedge clk_i);
			#1 hit = clr;
		end
	endtask
	task automatic wait_done();
		for (int k = 0; k < 400 && done_n !== 1'b0; k++)
			@(posedge clk_i);
		#1;
	endtask
	initial begin
		#300000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(32'h8030));
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 chk({31'h0, done_n}, 32'h1);
		chk({31'h0, ok}, 32'h0);
		$display("test reset done");
		st <= {1'b0, 8'($urandom)};
		q = 1 + $urandom % 3;
		n = 19 + 72 * q;
		s = '0;
		s[18:0] = {14'($urandom), 5'(q - 1)};
		for (int k = 0; k < q; k++) begin
			w[k] = 72'({$urandom, $urandom, $urandom});
			s = {s[162:0], w[k]};
		end
		mqrs_host_model_inst.master_reset();
		chk({25'h0, did, prim, ow, iw, fm}, {25'h0, st[6:0]});
		// Straps moved after release must not be taken
		st <= ~st;
		mqrs_host_model_inst.load(s, n, 1);
		repeat (10) @(posedge clk_i);
		#1 chk({31'h0, done_n}, 32'h1);
		chk({30'h0, cdone, ok}, 32'h0);
		mqrs_host_model_inst.load(s, 1, 0);
		wait_done();
		chk({31'h0, done_n}, 32'h0);
		chk({26'h0, qc}, 32'(q));
		chk({30'h0, cdone, ok}, 32'h3);
		chk({25'h0, did, prim, ow, iw, fm}, {25'h0, ~st[6:0]});
		mqrs_host_model_inst.pins(1'b1, 1'b1);
		#1 chk({30'h0, done_n, so}, 32'h3);
		mqrs_host_model_inst.pins(1'b0, 1'b0);
		#1 chk({30'h0, done_n, so}, 32'h0);
		mqrs_host_model_inst.pins(1'b1, 1'b1);
		for (int k = 0; k < q; k++) begin
			reg_wr(mqrs_pkg::REG_QSEL, 32'(k));
			reg_rd(mqrs_pkg::REG_QWORD0, r);
			chk(r, w[k][31:0]);
			reg_rd(mqrs_pkg::REG_QWORD1, r);
			chk(r, w[k][63:32]);
			reg_rd(mqrs_pkg::REG_QWORD2, r);
			chk(r & 32'hff, {24'h0, w[k][71:64]});
		end
		reg_rd(8'hfc, r);
		chk(r, 32'h0);
		$display("test serial done");
		part_reset(5'h03, 5'h04);
		chk({31'h0, hit}, 32'h0);
		repeat (40) @(posedge clk_i);
		#1 chk({31'h0, ok}, 32'h1);
		pq = 5'($urandom);
		part_reset(pq, pq);
		chk({31'h0, hit}, 32'h1);
		chk({27'h0, clrq}, {27'h0, pq});
		chk({26'h0, qc}, 32'(q));
		@(posedge clk_i);
		#1 chk({30'h0, clr, ok}, 32'h0);
		repeat (40) @(posedge clk_i);
		#1 chk({31'h0, ok}, 32'h1);
		$display("test partial reset done");
		for (int d = 0; d < 2; d++) begin
			st <= {1'b1, 1'(d), 7'($urandom)};
			ofs = d ? 16'h0080 : 16'h0008;
			mqrs_host_model_inst.pins(1'b0, 1'b0);
			mqrs_host_model_inst.master_reset();
			chk({29'h0, done_n, cdone, ok}, 32'h4);
			wait_done();
			chk({30'h0, done_n, cdone}, 32'h1);
			chk({26'h0, qc}, 32'd32);
			reg_rd(mqrs_pkg::REG_STATUS, r);
			chk(r & 32'h73f, 32'h720);
			reg_wr(mqrs_pkg::REG_QSEL, 32'h1f);
			reg_rd(mqrs_pkg::REG_QWORD0, r);
			chk(r, {ofs, ofs});
			reg_rd(mqrs_pkg::REG_QWORD1, r);
			chk(r & 32'hffff, 32'h0800);
			@(posedge clk_i);
			#1 chk(rdata, 32'h0);
		end
		$display("test default done");
		summarize();
	end
endmodule
